// ---- logic/rpm_power_reset.sv ----
// Power-mode and reset sequencer for an SPI relay driver
`timescale 1ns/1ps
module rpm_power_reset
  import rpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic bb_uv_ok,
  input wire logic dd_uv_ok,
  input wire logic frame_valid,
  input wire logic wake_cmd,
  input wire logic standby_command_bit,
  input wire logic reset_cmd,
  input wire logic error_clear,
  input wire logic [rpm_pkg::NUM_CH-1:0] ch_cmd,
  output logic [rpm_pkg::NUM_CH-1:0] ch_on,
  output logic frame_accept,
  output logic shift_enable,
  output logic bank_clear,
  output logic diag_clear,
  output logic uv_reset,
  output logic transmission_error_flag,
  output logic [1:0] power_state,
  output logic awake
);
  import rpm_pkg::*;

  // Synchronised supply monitors
  logic [1:0] sup_s;
  // Decoded supply status
  logic bb_ok;
  logic dd_ok;
  // Power state register and next value
  rpm_state_t state_r;
  rpm_state_t state_nxt;
  // Wake-up interval counter
  logic [WU_W-1:0] wu_cnt_r;
  logic [WU_W-1:0] wu_cnt_nxt;
  // Undervoltage reset held as a register
  logic uv_r;
  // Error flag register
  logic ter_r;
  // Channel register
  logic [NUM_CH-1:0] ch_r;
  // Any reset source this cycle
  logic any_reset;
  // Accepted frame, outside the wake-up window
  logic frame_ok;

  // Supplies are asynchronous levels; sync before use, reset value reads as bad
  rpm_sync2 #(
    .W(2),
    .RST_VAL(2'h0)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({bb_uv_ok, dd_uv_ok}),
    .q(sup_s)
  );

  assign bb_ok = sup_s[1];
  assign dd_ok = sup_s[0];

  // Undervoltage held while either supply is low; 3 cycles latency fits 1 us
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      uv_r <= 1'b1;
    end else begin
      uv_r <= !(bb_ok && dd_ok);
    end
  end

  // A frame only counts when the shift path is alive and not waking
  assign frame_ok = frame_valid && dd_ok && (state_r != RPM_WAKING);

  // Reset sources gathered in one term
  assign any_reset = uv_r || (frame_ok && reset_cmd);

  // Next power state
  always_comb begin
    state_nxt = state_r;
    wu_cnt_nxt = wu_cnt_r;
    case (state_r)
      RPM_SLEEP: begin
        // Standby while asleep is ignored
        if (frame_ok && wake_cmd) begin
          state_nxt = RPM_WAKING;
          wu_cnt_nxt = WU_W'(WAKEUP_CYCLES);
        end
      end
      RPM_WAKING: begin
        // Frames are dropped until initialisation ends
        if (wu_cnt_r == WU_ONE) begin
          state_nxt = RPM_ON;
          wu_cnt_nxt = WU_ZERO;
        end else begin
          wu_cnt_nxt = wu_cnt_r - WU_ONE;
        end
      end
      RPM_ON: begin
        // Wake while on is ignored
        if (frame_ok && standby_command_bit) begin
          state_nxt = RPM_SLEEP;
        end
      end
      default: begin
        state_nxt = RPM_SLEEP;
        wu_cnt_nxt = WU_ZERO;
      end
    endcase
    // Every reset lands in sleep
    if (any_reset) begin
      state_nxt = RPM_SLEEP;
      wu_cnt_nxt = WU_ZERO;
    end
  end

  // Power state register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= RPM_SLEEP;
      wu_cnt_r <= WU_ZERO;
    end else begin
      state_r <= state_nxt;
      wu_cnt_r <= wu_cnt_nxt;
    end
  end

  // Error flag: reset sets it, host clear loses to a concurrent set
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ter_r <= 1'b1;
    end else if (any_reset) begin
      ter_r <= 1'b1;
    end else if (frame_ok && error_clear) begin
      ter_r <= 1'b0;
    end
  end

  // Channels: only driven while operating, cleared by reset or sleep
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ch_r <= CH_DEFAULT;
    end else if (any_reset || state_nxt != RPM_ON) begin
      ch_r <= CH_DEFAULT;
    end else if (frame_ok) begin
      ch_r <= ch_cmd;
    end
  end

  // Bank clear pulses on reset or on entry to sleep; diag clear on reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bank_clear <= 1'b1;
      diag_clear <= 1'b1;
    end else begin
      bank_clear <= any_reset || (state_r != RPM_SLEEP && state_nxt == RPM_SLEEP);
      diag_clear <= any_reset;
    end
  end

  // Outputs
  assign ch_on = ch_r;
  assign frame_accept = frame_ok;
  assign shift_enable = dd_ok;
  assign uv_reset = uv_r;
  assign transmission_error_flag = ter_r;
  assign power_state = state_r;
  assign awake = (state_r == RPM_ON);

  // Helper: cycles spent in the waking state
  logic [WU_W-1:0] wake_age_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wake_age_r <= WU_ZERO;
    end else if (state_r == RPM_WAKING) begin
      wake_age_r <= wake_age_r + WU_ONE;
    end else begin
      wake_age_r <= WU_ZERO;
    end
  end

  // Power-up and reset leave the device asleep
  property p_reset_sleep;
    @(posedge clk_sys) disable iff (!nrst)
      any_reset |=> (state_r == RPM_SLEEP);
  endproperty
  a_reset_sleep: assert property (p_reset_sleep) else $error("state not sleep after reset");

  // Reset sets error flag next cycle
  property p_reset_ter;
    @(posedge clk_sys) disable iff (!nrst)
      any_reset |=> ter_r;
  endproperty
  a_reset_ter: assert property (p_reset_ter) else $error("error flag not set after reset");

  // Wake in sleep goes to waking
  property p_wake;
    @(posedge clk_sys) disable iff (!nrst)
      (state_r == RPM_SLEEP && frame_ok && wake_cmd && !any_reset) |=> (state_r == RPM_WAKING);
  endproperty
  a_wake: assert property (p_wake) else $error("wake command ignored");

  // Standby in operation returns to sleep
  property p_standby;
    @(posedge clk_sys) disable iff (!nrst)
      (state_r == RPM_ON && frame_ok && standby_command_bit) |=> (state_r == RPM_SLEEP);
  endproperty
  a_standby: assert property (p_standby) else $error("standby command ignored");

  // Waking never outlasts the wake-up time
  property p_wake_len;
    @(posedge clk_sys) disable iff (!nrst)
      (state_r == RPM_WAKING) |-> (wake_age_r < WU_W'(WAKEUP_CYCLES));
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake-up interval too long");

  // Frames during wake-up cannot cut the interval short
  property p_no_frame_waking;
    @(posedge clk_sys) disable iff (!nrst)
      (state_r == RPM_WAKING && wu_cnt_r != WU_ONE && !any_reset) |=> (state_r == RPM_WAKING);
  endproperty
  a_no_frame_waking: assert property (p_no_frame_waking) else $error("frame accepted during wake-up");

  // Either supply pin low shows as undervoltage three cycles later, well inside 1 us
  property p_uv_fast;
    @(posedge clk_sys) disable iff (!nrst)
      (!bb_uv_ok || !dd_uv_ok) |-> ##3 uv_r;
  endproperty
  a_uv_fast: assert property (p_uv_fast) else $error("undervoltage reset late");

  // Release only with both supplies good
  property p_uv_release;
    @(posedge clk_sys) disable iff (!nrst)
      $fell(uv_r) |-> $past(bb_ok) && $past(dd_ok);
  endproperty
  a_uv_release: assert property (p_uv_release) else $error("undervoltage released early");

  // Channels off whenever not operating
  property p_ch_off;
    @(posedge clk_sys) disable iff (!nrst)
      (state_r != RPM_ON) |-> (ch_r == CH_DEFAULT);
  endproperty
  a_ch_off: assert property (p_ch_off) else $error("channel on outside operation");

  // Reset command clears diagnosis
  property p_rst_cmd;
    @(posedge clk_sys) disable iff (!nrst)
      (frame_ok && reset_cmd) |=> (diag_clear && bank_clear);
  endproperty
  a_rst_cmd: assert property (p_rst_cmd) else $error("reset command did not clear");

  // Main scenarios
  c_wake_done: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(awake));
  c_standby: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(awake) && !uv_r);
  c_uv: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(uv_r));
  c_rst_cmd: cover property (@(posedge clk_sys) disable iff (!nrst) frame_ok && reset_cmd && !uv_r);
endmodule : rpm_power_reset

// ---- logic/rpm_pkg.sv ----
// Constants and types of the power-mode and reset sequencer
package rpm_pkg;
  // System clock rate in kHz
  localparam int unsigned CLK_KHZ = 50000;
  // Wake-up initialisation time, microseconds
  localparam int unsigned WAKEUP_INIT_US = 200;
  // Undervoltage reset delay ceiling, microseconds
  localparam int unsigned UV_RESET_MAX_US = 1;
  // Wake-up time in cycles (longest time, rounded down)
  localparam int unsigned WAKEUP_CYCLES = (WAKEUP_INIT_US * CLK_KHZ) / 1000;
  // Undervoltage delay budget in cycles (rounded down)
  localparam int unsigned UV_CYCLES = (UV_RESET_MAX_US * CLK_KHZ) / 1000;
  // Counter width for the wake-up interval
  localparam int unsigned WU_W = 14;
  // Number of output channels
  localparam int unsigned NUM_CH = 8;
  // Default channel enables after any reset
  localparam logic [7:0] CH_DEFAULT = 8'h00;
  // Counter constants
  localparam logic [WU_W-1:0] WU_ZERO = 14'h0000;
  localparam logic [WU_W-1:0] WU_ONE = 14'h0001;
  // Power states
  typedef enum logic [1:0] {RPM_SLEEP, RPM_WAKING, RPM_ON} rpm_state_t;
endpackage : rpm_pkg

// ---- logic/rpm_sync2.sv ----
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module rpm_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by second stage
  logic [W-1:0] meta_r;

  // Plain two-stage chain; reset value guards startup
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : rpm_sync2

// ---- test/rpm_host_model.sv ----
// Host controller model that issues one-cycle command frames
`timescale 1ns/1ps
module rpm_host_model
  import rpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic frame_accept,
  output logic frame_valid,
  output logic wake_cmd,
  output logic standby_command_bit,
  output logic reset_cmd,
  output logic error_clear,
  output logic [rpm_pkg::NUM_CH-1:0] ch_cmd
);
  // Idle lines at time zero
  initial begin
    frame_valid = 1'b0;
    {wake_cmd, standby_command_bit, reset_cmd, error_clear} = 4'h0;
    ch_cmd = 8'h00;
  end
  // One frame: bits are wake, standby, reset, clear; acc shows whether it was taken
  task automatic send(input logic [3:0] b, input logic [7:0] ch, output logic acc);
    // One idle edge first, so back-to-back frames never lower and raise valid in one step
    @(posedge clk_sys);
    #1;
    {wake_cmd, standby_command_bit, reset_cmd, error_clear} = b;
    ch_cmd = ch;
    frame_valid = 1'b1;
    #5 acc = frame_accept;
    @(posedge clk_sys);
    #1 frame_valid = 1'b0;
    // Unqualified lines show the inverse so stale bits never pass
    {wake_cmd, standby_command_bit, reset_cmd, error_clear} = ~b;
    ch_cmd = ~ch;
  endtask : send
  // Hold off further frames for the whole wake-up time
  task automatic wake_wait();
    repeat (WAKEUP_CYCLES + 4) @(posedge clk_sys);
    #1;
  endtask : wake_wait
endmodule : rpm_host_model

// ---- test/relay_driver_power_mode_reset_test.sv ----
// Self-checking bench for the power-mode and reset sequencer
`timescale 1ns/1ps
module relay_driver_power_mode_reset_test;
  import rpm_pkg::*;
  logic clk_sys, nrst, bb_uv_ok, dd_uv_ok, frame_valid, wake_cmd, standby_command_bit, reset_cmd, error_clear;
  logic [7:0] ch_cmd, ch_on;
  logic frame_accept, shift_enable, bank_clear, diag_clear, uv_reset, transmission_error_flag, awake, acc;
  logic [1:0] power_state;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Device under test
  rpm_power_reset i_rpm_power_reset (.clk_sys(clk_sys), .nrst(nrst), .bb_uv_ok(bb_uv_ok), .dd_uv_ok(dd_uv_ok),
    .frame_valid(frame_valid), .wake_cmd(wake_cmd), .standby_command_bit(standby_command_bit),
    .reset_cmd(reset_cmd), .error_clear(error_clear), .ch_cmd(ch_cmd), .ch_on(ch_on),
    .frame_accept(frame_accept), .shift_enable(shift_enable), .bank_clear(bank_clear),
    .diag_clear(diag_clear), .uv_reset(uv_reset), .transmission_error_flag(transmission_error_flag),
    .power_state(power_state), .awake(awake));
  // Far-side host
  rpm_host_model i_rpm_host_model (.clk_sys(clk_sys), .frame_accept(frame_accept), .frame_valid(frame_valid),
    .wake_cmd(wake_cmd), .standby_command_bit(standby_command_bit), .reset_cmd(reset_cmd),
    .error_clear(error_clear), .ch_cmd(ch_cmd));
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Verdict and end of run
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Compare one value, case equality so unknowns fail
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Cycle steps
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // Wait at most the 1 us budget for the reset level
  task automatic wuv(input logic v);
    for (int k = 0; k < UV_CYCLES && uv_reset !== v; k++) tick(1);
    chk(uv_reset, v);
  endtask : wuv
  // One frame through the host
  task automatic frm(input logic [3:0] b, input logic [7:0] ch);
    i_rpm_host_model.send(b, ch, acc);
  endtask : frm
  // Wake and let the initialisation finish
  task automatic wake();
    frm(4'h8, 8'h00);
    i_rpm_host_model.wake_wait();
  endtask : wake
  // Hang guard, well above the four wake-ups
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    bb_uv_ok = 1'b1;
    dd_uv_ok = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 nrst = 1'b1;
    chk(transmission_error_flag, 8'h01);
    chk(ch_on, 8'h00);
    wuv(1'b0);
    chk(power_state, RPM_SLEEP);
    chk(shift_enable, 8'h01);
    // Standby while asleep does nothing
    frm(4'h4, 8'h00);
    chk(bank_clear, 8'h00);
    chk(power_state, RPM_SLEEP);
    // Wake, then a too-early frame is refused
    frm(4'h8, 8'hff);
    chk(power_state, RPM_WAKING);
    frm(4'h0, 8'hff);
    chk(acc, 8'h00);
    chk(ch_on, 8'h00);
    tick(9990);
    chk(awake, 8'h00);
    i_rpm_host_model.wake_wait();
    chk(power_state, RPM_ON);
    chk(awake, 8'h01);
    frm(4'h0, 8'ha5);
    chk(ch_on, 8'ha5);
    frm(4'h8, 8'ha5);
    chk(power_state, RPM_ON);
    chk(diag_clear, 8'h00);
    // Standby clears banks and channels
    frm(4'h4, 8'ha5);
    chk(power_state, RPM_SLEEP);
    chk(bank_clear, 8'h01);
    chk(ch_on, 8'h00);
    // Reset command beats wake in the same frame
    wake();
    frm(4'h1, 8'h3c);
    chk(transmission_error_flag, 8'h00);
    chk(ch_on, 8'h3c);
    frm(4'ha, 8'h3c);
    chk(power_state, RPM_SLEEP);
    chk(diag_clear, 8'h01);
    chk(bank_clear, 8'h01);
    chk(transmission_error_flag, 8'h01);
    chk(ch_on, 8'h00);
    // Reset and wake together while asleep: reset wins
    frm(4'ha, 8'h00);
    chk(power_state, RPM_SLEEP);
    chk(diag_clear, 8'h01);
    // Logic supply loss
    wake();
    frm(4'h0, 8'h0f);
    dd_uv_ok = 1'b0;
    tick(3);
    chk(shift_enable, 8'h00);
    wuv(1'b1);
    frm(4'h0, 8'h0f);
    chk(acc, 8'h00);
    chk(ch_on, 8'h00);
    dd_uv_ok = 1'b1;
    wuv(1'b0);
    chk(power_state, RPM_SLEEP);
    // Battery loss while on
    wake();
    frm(4'h0, 8'hf0);
    bb_uv_ok = 1'b0;
    wuv(1'b1);
    tick(2);
    chk(power_state, RPM_SLEEP);
    chk(ch_on, 8'h00);
    frm(4'h1, 8'h00);
    chk(acc, 8'h01);
    tick(1);
    chk(transmission_error_flag, 8'h01);
    // Release needs both supplies good
    dd_uv_ok = 1'b0;
    bb_uv_ok = 1'b1;
    tick(10);
    chk(uv_reset, 8'h01);
    dd_uv_ok = 1'b1;
    wuv(1'b0);
    // Clear the flag, then a mid-run reset pulse sets it again
    frm(4'h1, 8'h00);
    chk(transmission_error_flag, 8'h00);
    nrst = 1'b0;
    tick(2);
    chk(uv_reset, 8'h01);
    chk(transmission_error_flag, 8'h01);
    chk(bank_clear, 8'h01);
    nrst = 1'b1;
    wuv(1'b0);
    chk(power_state, RPM_SLEEP);
    chk(transmission_error_flag, 8'h01);
    summarize();
  end
endmodule : relay_driver_power_mode_reset_test
